// [nvc_pkg.sv]
// Shared constants and types for the nonvolatile data array access controller
package nvc_pkg;
   localparam int NVC_CLK_HZ = 25_000_000;
   localparam int NVC_CYC_PER_US = NVC_CLK_HZ / 1_000_000;
   localparam int NVC_PWRT_US = 64;
   localparam int NVC_PWRT_CYC = NVC_PWRT_US * NVC_CYC_PER_US;
   localparam int NVC_WRITE_US = 4000;
   localparam int NVC_WRITE_CYC = NVC_WRITE_US * NVC_CYC_PER_US;
   localparam int NVC_DEPTH = 256;
   localparam logic [7:0] NVC_OFS_ADDR = 8'h00;
   localparam logic [7:0] NVC_OFS_DATA = 8'h04;
   localparam logic [7:0] NVC_OFS_KEY = 8'h08;
   localparam logic [7:0] NVC_OFS_CTRL = 8'h0c;
   localparam logic [7:0] NVC_OFS_STAT = 8'h10;
   localparam logic [7:0] NVC_KEY1 = 8'h55;
   localparam logic [7:0] NVC_KEY2 = 8'haa;
   localparam int NVC_B_PSEL = 7;
   localparam int NVC_B_CSEL = 6;
   localparam int NVC_B_FREE = 4;
   localparam int NVC_B_ABORT = 3;
   localparam int NVC_B_WRITE_UNLOCK_ENABLE = 2;
   localparam int NVC_B_WR = 1;
   localparam int NVC_B_RD = 0;
   localparam int NVC_S_DONE = 0;
   localparam int NVC_S_BUSY = 1;
   localparam int NVC_S_PWRT = 2;
   localparam logic [7:0] NVC_ADDR_RST = 8'h00;
   localparam logic [7:0] NVC_DATA_RST = 8'h00;
   localparam logic NVC_BIT_RST = 1'b0;
   typedef enum logic [1:0] {NVC_K_IDLE, NVC_K_ONE, NVC_K_TWO} nvc_key_e;
endpackage

// [nvc_array.sv]
// Byte-wide storage array with one write port and two asynchronous read ports
`timescale 1ns/10ps
module nvc_array #(
   parameter int DEPTH = 256
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [$clog2(DEPTH)-1:0] raddr_a,
   output logic [7:0] rdata_a,
   input wire logic [$clog2(DEPTH)-1:0] raddr_b,
   output logic [7:0] rdata_b
);
   // Contents are deliberately not reset: they stand for nonvolatile cells
   logic [7:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata_a = mem[raddr_a];
   assign rdata_b = mem[raddr_b];
endmodule

// [nvc_access_ctrl.sv]
// Access controller for the nonvolatile data array, AHB-Lite register slave
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
module nvc_access_ctrl import nvc_pkg::*; #(
   parameter int WRITE_CYCLES = NVC_WRITE_CYC,
   parameter int PWRT_CYCLES = NVC_PWRT_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic por_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic code_protect,
   input wire logic ext_req,
   input wire logic ext_we,
   input wire logic [7:0] ext_addr,
   input wire logic [7:0] ext_wdata,
   output logic [7:0] ext_rdata,
   output logic ext_ack,
   output logic write_done_flag,
   output logic write_busy
);
   localparam int CW = $clog2(WRITE_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(WRITE_CYCLES - 1);
   localparam int PW = $clog2(PWRT_CYCLES + 1);
   localparam logic [PW-1:0] PWRT_LAST = PW'(PWRT_CYCLES - 1);

   generate
      if (WRITE_CYCLES < 1 || PWRT_CYCLES < 1) begin : g_bad_param
         $error("nvc_access_ctrl: cycle counts must be at least one");
      end
   endgenerate

   function automatic logic hit(input logic [7:0] ofs, input logic [7:0] want);
      hit = (ofs == want);
   endfunction

   // Bus slave: writes finish with no wait, reads take one wait state so the
   // read mux sees any register update made by the write just before it
   logic ap_wr_reg, ap_rd_reg, take;
   logic [7:0] ap_ofs_reg, rd_mux;
   logic [31:0] hrdata_reg;

   assign take = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_reg <= 1'b0;
         ap_rd_reg <= 1'b0;
         ap_ofs_reg <= 8'h00;
      end else begin
         ap_wr_reg <= take && hwrite;
         ap_rd_reg <= take && !hwrite;
         if (take) begin
            ap_ofs_reg <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (ap_rd_reg) begin
         hrdata_reg <= {24'h00_0000, rd_mux};
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = !ap_rd_reg;
   assign hresp = 1'b0;

   logic [7:0] wdat;
   logic w_addr, w_data, w_key, w_ctrl, w_stat;

   assign wdat = hwdata[7:0];
   assign w_addr = ap_wr_reg && hit(ap_ofs_reg, NVC_OFS_ADDR);
   assign w_data = ap_wr_reg && hit(ap_ofs_reg, NVC_OFS_DATA);
   assign w_key = ap_wr_reg && hit(ap_ofs_reg, NVC_OFS_KEY);
   assign w_ctrl = ap_wr_reg && hit(ap_ofs_reg, NVC_OFS_CTRL);
   assign w_stat = ap_wr_reg && hit(ap_ofs_reg, NVC_OFS_STAT);

   // Control and state registers
   logic psel_reg, csel_reg, free_reg, abort_reg, write_unlock_enable_reg, wr_reg;
   logic done_reg, pend_reg, rel_reg, pwrt_active_reg;
   logic [7:0] addr_reg, data_reg;
   logic [CW-1:0] cnt_reg;
   logic [PW-1:0] pwrt_cnt_reg;
   nvc_key_e key_reg, key_next;
   logic wr_try, start, bad_try, rd_go, done_evt;
   logic [7:0] arr_rdata, ext_arr_rdata;

   // Unlock key checker; the port itself keeps no readable value
   always_comb begin
      key_next = NVC_K_IDLE;
      case (key_reg)
         NVC_K_IDLE: key_next = (wdat == NVC_KEY1) ? NVC_K_ONE : NVC_K_IDLE;
         NVC_K_ONE: key_next = (wdat == NVC_KEY2) ? NVC_K_TWO : NVC_K_IDLE;
         NVC_K_TWO: key_next = (wdat == NVC_KEY1) ? NVC_K_ONE : NVC_K_IDLE;
         default: key_next = NVC_K_IDLE;
      endcase
   end

   // Any bus write other than the next key breaks the sequence
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         key_reg <= NVC_K_IDLE;
      end else if (w_key) begin
         key_reg <= key_next;
      end else if (ap_wr_reg) begin
         key_reg <= NVC_K_IDLE;
      end
   end

   assign wr_try = w_ctrl && wdat[NVC_B_WR] && !wr_reg;
   // Enable must already be set: enable and start in one write do not start
   assign start = wr_try && write_unlock_enable_reg && key_reg == NVC_K_TWO && !pwrt_active_reg;
   assign bad_try = wr_try && !start;
   assign rd_go = w_ctrl && !wr_reg && wdat[NVC_B_RD] &&
                  !wdat[NVC_B_PSEL] && !wdat[NVC_B_CSEL];
   assign done_evt = wr_reg && cnt_reg == CNT_LAST;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         psel_reg <= NVC_BIT_RST;
         csel_reg <= NVC_BIT_RST;
         free_reg <= NVC_BIT_RST;
         write_unlock_enable_reg <= NVC_BIT_RST;
      end else if (w_ctrl && !wr_reg) begin
         psel_reg <= wdat[NVC_B_PSEL];
         csel_reg <= wdat[NVC_B_CSEL];
         free_reg <= wdat[NVC_B_FREE];
         write_unlock_enable_reg <= wdat[NVC_B_WRITE_UNLOCK_ENABLE];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_reg <= NVC_BIT_RST;
      end else if (start) begin
         wr_reg <= 1'b1;
      end else if (done_evt) begin
         wr_reg <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= '0;
      end else if (!wr_reg) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + CW'(1);
      end
   end

   // Survives a bus reset so an interrupted write can be reported afterwards
   always_ff @(posedge hclk or negedge por_n) begin
      if (!por_n) begin
         pend_reg <= 1'b0;
      end else if (start) begin
         pend_reg <= 1'b1;
      end else if (done_evt) begin
         pend_reg <= 1'b0;
      end else if (rel_reg && !wr_reg) begin
         pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rel_reg <= 1'b0;
      end else begin
         rel_reg <= 1'b1;
      end
   end

   // Space selects still load from the control write when a refused start raises the abort flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         abort_reg <= NVC_BIT_RST;
      end else if ((!rel_reg && pend_reg) || bad_try) begin
         abort_reg <= 1'b1;
      end else if (done_evt) begin
         abort_reg <= 1'b0;
      end else if (w_ctrl && !wr_reg) begin
         abort_reg <= wdat[NVC_B_ABORT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwrt_cnt_reg <= '0;
         pwrt_active_reg <= 1'b1;
      end else if (pwrt_active_reg) begin
         pwrt_cnt_reg <= pwrt_cnt_reg + PW'(1);
         if (pwrt_cnt_reg == PWRT_LAST) begin
            pwrt_active_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_reg <= NVC_ADDR_RST;
      end else if (w_addr && !wr_reg) begin
         addr_reg <= wdat;
      end
   end

   // Read data lands in the same edge as the start write; code protect is
   // not consulted on the internal path
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_reg <= NVC_DATA_RST;
      end else if (rd_go) begin
         data_reg <= arr_rdata;
      end else if (w_data && !wr_reg) begin
         data_reg <= wdat;
      end
   end

   // Done flag: cleared by writing one, a completion in the same cycle wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_reg <= NVC_BIT_RST;
      end else if (done_evt) begin
         done_reg <= 1'b1;
      end else if (w_stat && wdat[NVC_S_DONE]) begin
         done_reg <= 1'b0;
      end
   end

   assign write_done_flag = done_reg;
   assign write_busy = wr_reg;

   always_comb begin
      rd_mux = 8'h00;
      case (ap_ofs_reg)
         NVC_OFS_ADDR: rd_mux = addr_reg;
         NVC_OFS_DATA: rd_mux = data_reg;
         NVC_OFS_KEY: rd_mux = 8'h00;
         NVC_OFS_CTRL: rd_mux = {psel_reg, csel_reg, 1'b0, free_reg,
                                 abort_reg, write_unlock_enable_reg, wr_reg, 1'b0};
         NVC_OFS_STAT: rd_mux = {5'h00, pwrt_active_reg, wr_reg, done_reg};
         default: rd_mux = 8'h00;
      endcase
   end

   // External programming port: pins pass a two-stage synchroniser; the
   // request is a level and its rising edge triggers one access
   logic [18:0] ext_s1_reg, ext_s2_reg;
   logic ext_req_d_reg;
   logic ext_go, ext_write, req_s, we_s, prot_s;
   logic [7:0] ext_rdata_reg, eaddr_s, edata_s;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_s1_reg <= '0;
         ext_s2_reg <= '0;
         ext_req_d_reg <= 1'b0;
      end else begin
         ext_s1_reg <= {ext_req, ext_we, code_protect, ext_addr, ext_wdata};
         ext_s2_reg <= ext_s1_reg;
         ext_req_d_reg <= req_s;
      end
   end

   assign {req_s, we_s, prot_s, eaddr_s, edata_s} = ext_s2_reg;
   assign ext_go = req_s && !ext_req_d_reg;
   // An external write during a timed write is dropped
   assign ext_write = ext_go && we_s && !prot_s && !wr_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_rdata_reg <= 8'h00;
      end else if (ext_go && !we_s) begin
         ext_rdata_reg <= prot_s ? 8'h00 : ext_arr_rdata;
      end
   end

   assign ext_rdata = ext_rdata_reg;
   assign ext_ack = ext_req_d_reg;

   logic arr_we;
   logic [7:0] arr_waddr, arr_wdata;

   assign arr_we = done_evt || ext_write;
   assign arr_waddr = done_evt ? addr_reg : eaddr_s;
   assign arr_wdata = done_evt ? data_reg : edata_s;

   nvc_array #(
      .DEPTH(NVC_DEPTH)
   ) u_array (
      .clk(hclk),
      .we(arr_we),
      .waddr(arr_waddr),
      .wdata(arr_wdata),
      .raddr_a(addr_reg),
      .rdata_a(arr_rdata),
      .raddr_b(eaddr_s),
      .rdata_b(ext_arr_rdata)
   );

   unlock_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ap_rd_reg && hit(ap_ofs_reg, NVC_OFS_KEY) |=> hrdata == 32'h0)
      else $error("unlock port read not zero");
   start_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(wr_reg) |-> $past(key_reg) == NVC_K_TWO && $past(w_ctrl))
      else $error("write started without key order");
   read_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_go |=> data_reg == $past(arr_rdata))
      else $error("read did not load data register");
   done_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      done_evt |=> !wr_reg && done_reg && !abort_reg)
      else $error("write end did not clear start and set done");
   pwrt_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
      pwrt_active_reg |-> !start)
      else $error("write started during power-up timer");
   write_unlock_enable_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(wr_reg) |-> $past(write_unlock_enable_reg))
      else $error("write started without enable");
   lock_regs_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_reg && $past(wr_reg) |-> $stable(addr_reg) && $stable(data_reg) && $stable(write_unlock_enable_reg))
      else $error("registers changed during write");
   bad_try_a: assert property (@(posedge hclk) disable iff (!hresetn)
      bad_try |=> abort_reg && psel_reg == $past(wdat[NVC_B_PSEL]) &&
                  csel_reg == $past(wdat[NVC_B_CSEL]))
      else $error("improper write did not raise abort");
   rd_refuse_a: assert property (@(posedge hclk) disable iff (!hresetn)
      w_ctrl && (wdat[NVC_B_PSEL] || wdat[NVC_B_CSEL]) |=> $stable(data_reg))
      else $error("read ran with space select set");
   write_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_reg |-> cnt_reg <= CNT_LAST)
      else $error("write counter overran");
   bit5_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ap_rd_reg && hit(ap_ofs_reg, NVC_OFS_CTRL) |=> hrdata[5] == 1'b0)
      else $error("control bit 5 read as one");
   protect_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ext_go && prot_s |=> ($past(we_s) || ext_rdata == 8'h00) && !$past(ext_write))
      else $error("external access under protect");
endmodule

// [nvc_access_ctrl_bench.sv]
// Self-checking bench for the nonvolatile data array access controller
`timescale 1ns/10ps
module nvc_access_ctrl_bench import nvc_pkg::*;;
   // Short counts keep the run brief; the write-length expectation derives from WCYC
   localparam int WCYC = 20;
   localparam int PCYC = 12;
   logic hclk, hresetn, por_n, hsel, hwrite, code_protect, ext_req, ext_we;
   logic hreadyout, hresp, ext_ack, write_done_flag, write_busy;
   logic [31:0] haddr, hwdata, hrdata, rw;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] ext_addr, ext_wdata, ext_rdata, rv;
   int n_fail, n_checks, n;

   nvc_access_ctrl #(.WRITE_CYCLES(WCYC), .PWRT_CYCLES(PCYC)) u_nvc_access_ctrl (
      .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .code_protect(code_protect), .ext_req(ext_req), .ext_we(ext_we),
      .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
      .ext_ack(ext_ack), .write_done_flag(write_done_flag), .write_busy(write_busy));

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Entered just after a rising edge; each phase is held until hready is seen high
   task automatic xfer(input logic [7:0] a, input logic wr, input logic [7:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h000000, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rw = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
      xfer(a, 1'b0, 8'h00);
      chk32(what, {24'h000000, exp}, rw);
   endtask

   task automatic unlock(input logic [7:0] k1, input logic [7:0] k2);
      wr(NVC_OFS_KEY, k1);
      wr(NVC_OFS_KEY, k2);
      wr(NVC_OFS_CTRL, 8'h06);
   endtask

   // Completion is seen by polling the start bit, as software would
   task automatic wait_done();
      do xfer(NVC_OFS_CTRL, 1'b0, 8'h00); while (rw[NVC_B_WR] !== 1'b0);
   endtask

   task automatic rd_byte(input logic [7:0] a, input logic [7:0] exp);
      wr(NVC_OFS_ADDR, a);
      wr(NVC_OFS_CTRL, 8'h05);
      rdc(NVC_OFS_DATA, exp, "array byte");
   endtask

   task automatic ext(input logic we, input logic [7:0] a, input logic [7:0] d);
      ext_we <= we;
      ext_addr <= a;
      ext_wdata <= d;
      ext_req <= 1'b1;
      do @(posedge hclk); while (ext_ack !== 1'b1);
      rv = ext_rdata;
      ext_req <= 1'b0;
      do @(posedge hclk); while (ext_ack !== 1'b0);
   endtask

   task automatic t_powerup();
      rdc(NVC_OFS_STAT, 8'h04, "status at power-up");
      wr(NVC_OFS_CTRL, 8'h04);
      unlock(NVC_KEY1, NVC_KEY2);
      rdc(NVC_OFS_CTRL, 8'h0c, "start in power-up time");
      do xfer(NVC_OFS_STAT, 1'b0, 8'h00); while (rw[NVC_S_PWRT] !== 1'b0);
      chk32("status after timer", 32'h00000000, rw);
   endtask

   task automatic t_write();
      wr(NVC_OFS_ADDR, 8'h5a);
      wr(NVC_OFS_DATA, 8'h3c);
      wr(NVC_OFS_CTRL, 8'h04);
      unlock(NVC_KEY1, NVC_KEY2);
      #1;
      chk8("busy after start", 8'h01, {7'h00, write_busy});
      chk8("bus response", 8'h00, {7'h00, hresp});
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (write_busy === 1'b1);
      chk8("write length", 8'(WCYC), 8'(n - 1));
      wait_done();
      rdc(NVC_OFS_CTRL, 8'h04, "control after write");
      rdc(NVC_OFS_STAT, 8'h01, "done flag");
      chk8("done port", 8'h01, {7'h00, write_done_flag});
      wr(NVC_OFS_STAT, 8'h01);
      rdc(NVC_OFS_STAT, 8'h00, "done flag cleared");
      rd_byte(8'h5a, 8'h3c);
   endtask

   task automatic t_refused();
      wr(NVC_OFS_CTRL, 8'h04);
      unlock(NVC_KEY2, NVC_KEY1);
      rdc(NVC_OFS_CTRL, 8'h0c, "keys reversed");
      wr(NVC_OFS_CTRL, 8'h04);
      wr(NVC_OFS_KEY, NVC_KEY1);
      wr(NVC_OFS_DATA, 8'h3c);
      wr(NVC_OFS_KEY, NVC_KEY2);
      wr(NVC_OFS_CTRL, 8'h06);
      rdc(NVC_OFS_CTRL, 8'h0c, "keys interrupted");
      wr(NVC_OFS_CTRL, 8'h00);
      unlock(NVC_KEY1, NVC_KEY2);
      rdc(NVC_OFS_CTRL, 8'h0c, "start without enable");
   endtask

   task automatic t_lock();
      wr(NVC_OFS_CTRL, 8'h04);
      wr(NVC_OFS_ADDR, 8'h5b);
      wr(NVC_OFS_DATA, 8'h77);
      unlock(NVC_KEY1, NVC_KEY2);
      wr(NVC_OFS_ADDR, 8'h00);
      wr(NVC_OFS_DATA, 8'h00);
      wr(NVC_OFS_CTRL, 8'hc4);
      wait_done();
      rdc(NVC_OFS_ADDR, 8'h5b, "address locked");
      rdc(NVC_OFS_DATA, 8'h77, "data locked");
      rdc(NVC_OFS_CTRL, 8'h04, "control locked");
      rd_byte(8'h5a, 8'h3c);
      rd_byte(8'h5b, 8'h77);
   endtask

   task automatic t_select();
      wr(NVC_OFS_ADDR, 8'h5a);
      wr(NVC_OFS_CTRL, 8'hf5);
      rdc(NVC_OFS_CTRL, 8'hd4, "selects set, bit 5");
      rdc(NVC_OFS_DATA, 8'h77, "read start refused");
      wr(NVC_OFS_CTRL, 8'h04);
   endtask

   task automatic t_protect();
      code_protect <= 1'b1;
      repeat (4) @(posedge hclk);
      ext(1'b0, 8'h5a, 8'h00);
      chk8("protected outside read", 8'h00, rv);
      ext(1'b1, 8'h5a, 8'h99);
      rd_byte(8'h5a, 8'h3c);
      code_protect <= 1'b0;
      repeat (4) @(posedge hclk);
      ext(1'b0, 8'h5a, 8'h00);
      chk8("open outside read", 8'h3c, rv);
      ext(1'b1, 8'h10, 8'h42);
      rd_byte(8'h10, 8'h42);
   endtask

   // Known pattern loaded from outside, then every byte refreshed from address zero
   task automatic t_refresh();
      logic [7:0] a;
      a = 8'h00;
      for (int i = 0; i < NVC_DEPTH; i++) begin
         ext(1'b1, 8'(i), 8'(i) ^ 8'ha5);
      end
      do begin
         wr(NVC_OFS_STAT, 8'h01);
         wr(NVC_OFS_ADDR, a);
         wr(NVC_OFS_CTRL, 8'h05);
         rdc(NVC_OFS_DATA, a ^ 8'ha5, "refresh read");
         unlock(NVC_KEY1, NVC_KEY2);
         wait_done();
         chk8("refresh done", 8'h01, {7'h00, write_done_flag});
         a++;
      end while (a != 8'h00);
      rdc(NVC_OFS_CTRL, 8'h04, "control after refresh");
      for (int i = 0; i < NVC_DEPTH; i++) begin
         ext(1'b0, 8'(i), 8'h00);
         chk8("refreshed byte", 8'(i) ^ 8'ha5, rv);
      end
   endtask

   // Reset lands while the timed write is still running
   task automatic t_reset();
      wr(NVC_OFS_ADDR, 8'h20);
      wr(NVC_OFS_DATA, 8'h11);
      unlock(NVC_KEY1, NVC_KEY2);
      repeat (3) @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(NVC_OFS_CTRL, 8'h08, "control after cut write");
      rdc(NVC_OFS_STAT, 8'h04, "timer after reset");
      rdc(NVC_OFS_KEY, 8'h00, "unlock port read");
      rdc(8'h14, 8'h00, "unmapped read");
   endtask

   initial begin
      n_fail = 0;
      n_checks = 0;
      hresetn = 1'b0;
      por_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h00000000;
      code_protect = 1'b0;
      ext_req = 1'b0;
      ext_we = 1'b0;
      ext_addr = 8'h00;
      ext_wdata = 8'h00;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      por_n <= 1'b1;
      t_powerup();
      t_write();
      t_refused();
      t_lock();
      t_select();
      t_protect();
      t_refresh();
      t_reset();
      results();
   end

   // The full-array refresh dominates: roughly 15000 cycles in all
   initial begin
      repeat (40000) @(posedge hclk);
      n_fail++;
      $display("Watchdog expired before the sequence ended");
      results();
   end
endmodule
